// *** rtl/slc_defines.svh ***
`ifndef SLC_DEFINES_SVH
`define SLC_DEFINES_SVH

// ==========================================================================
// geometry
`define SLC_NCH             4
`define SLC_NSRC            5
`define SLC_NPIN            3

// ==========================================================================
// command byte of the serial host port
`define SLC_CMD_RW          7
`define SLC_CMD_TYPE_HI     6
`define SLC_CMD_TYPE_LO     5
`define SLC_CMD_ADDR_HI     4
`define SLC_CMD_ADDR_LO     0
`define SLC_TYPE_LOCAL      2'h0
`define SLC_TYPE_GLOBAL     2'h1
`define SLC_BIT_LAST        3'h7
`define SLC_TX_LAST         4'hF

// ==========================================================================
// global register addresses
`define SLC_G_INT_CLEAR     5'h02
`define SLC_G_CH_ENABLE     5'h06
`define SLC_G_TRIP_CFG      5'h08
`define SLC_G_DEB_STATUS    5'h09
`define SLC_G_PIN_ONE       5'h0A
`define SLC_G_PIN_TWO       5'h0B
`define SLC_G_PIN_THREE     5'h0C

// ==========================================================================
// local register addresses
`define SLC_L_INT_ENABLE    5'h02
`define SLC_L_DEB_PERIODS   5'h03
`define SLC_L_SIG_PINS      5'h04

// ==========================================================================
// ring_trip_config fields
`define SLC_TRIP_EN         7
`define SLC_TRIP_IN_SEL     6
`define SLC_TRIP_OUT_HI     5
`define SLC_TRIP_OUT_LO     3
`define SLC_TRIP_IN_POL     2
`define SLC_TRIP_OUT_POL    1
`define SLC_TRIP_CFG_MASK   8'hFE

// output select codes, also the bit order of a channel's output vector (line one, line two, pins one to three)
`define SLC_OSEL_LINE_ONE   3'h0
`define SLC_OSEL_LINE_TWO   3'h1
`define SLC_OSEL_PIN_ONE    3'h2
`define SLC_OSEL_PIN_THREE  3'h4

// ==========================================================================
// channel source bits (interrupt_enable, channel_signal_pins)
`define SLC_SRC_HOOK        0
`define SLC_SRC_KEY         1
`define SLC_SRC_PIN_ONE     2
`define SLC_SIG_LINE_ONE    5
`define SLC_SIG_LINE_TWO    6

// debounce_periods fields; debounced_input_status holds key high, hook low
`define SLC_HOOK_PER_HI     7
`define SLC_HOOK_PER_LO     4
`define SLC_KEY_PER_HI      3
`define SLC_KEY_PER_LO      0

// ==========================================================================
// timing, paced by frame sync
`define SLC_FRAME_NS        125000
`define SLC_SAMPLE_NS       250000
`define SLC_STEP_NS         2000000
`define SLC_SAMPLE_FRAMES   4'((`SLC_SAMPLE_NS) / (`SLC_FRAME_NS))
`define SLC_STEP_FRAMES     4'(((`SLC_STEP_NS) / (`SLC_FRAME_NS)) - 1)
`define SLC_KEY_TOP         3'h6
`define SLC_KEY_BOTTOM      3'h0
`define SLC_ZERO_PERIOD     4'h0

// ==========================================================================
// reset values
`define SLC_RST_BYTE        8'h00
`define SLC_RST_CH_EN       4'h1

`endif

// *** rtl/slc_pkg.sv ***
`include "slc_defines.svh"

package slc_pkg;

	typedef enum logic [1:0]
	{
		SLC_PS_CMD   = 2'b00,
		SLC_PS_WDATA = 2'b01,
		SLC_PS_READ  = 2'b10,
		SLC_PS_DONE  = 2'b11
	} slc_port_state_t;

	typedef struct packed
	{
		logic                  fs_q;
		logic                  sclk_q;
		logic [3:0]            samp_cnt;
		logic [3:0]            step_cnt;
		logic [3:0]            hook_smp;
		logic [3:0][3:0]       hook_cnt;
		logic [3:0]            hook_db;
		logic [3:0][3:0]       key_tmr;
		logic [3:0][2:0]       key_cnt;
		logic [3:0]            key_db;
		logic [3:0]            ch_en;
		logic [7:0]            trip_cfg;
		logic [2:0][3:0]       pin_dir;
		logic [2:0][3:0]       pin_val;
		logic [3:0][1:0]       line_val;
		logic [3:0][4:0]       int_en;
		logic [3:0][7:0]       deb_per;
		logic [3:0][4:0]       src_q;
		logic [3:0][4:0]       pend;
		slc_port_state_t       port_st;
		logic [2:0]            bit_cnt;
		logic [7:0]            rx_sr;
		logic [7:0]            cmd;
		logic [15:0]           tx_sr;
		logic [3:0]            tx_cnt;
		logic                  sdo;
		logic                  sdo_oe;
		logic [3:0]            line_one_drv;
		logic [3:0]            line_two_drv;
		logic [2:0][3:0]       pin_drv;
		logic                  irq;
	} slc_state_t;

endpackage

// *** rtl/slc_signaling.sv ***
// Function
// - each channel has two inputs, three bidirectional pins and two outputs
// - global status holds debounced hook and key bits, channel 4 down to 1
// - each channel register also returns its hook and key state
// - one global register per bidirectional pin holds direction bits, 1 means output
// - input-mode pin level reads in its global register and channel register
// - output-mode pin level is set only by its global pin register
// - line outputs come only from channel register, reading returns last write
// - ring trip acts only while its enable bit is 1
// - one bit selects off-hook input, three bits select ring output
// - valid off-hook at once inverts the selected output while its register value is the ringing level
// - input polarity 0 means low is off-hook, 1 means high
// - output polarity 1 idles low rings high, 0 idles high rings low
// - every change on a signaling input raises an interrupt
// - five enable bits per channel gate each interrupt source
// - any write to interrupt clear register clears all pending interrupts
// - reading debounced status clears hook and key interrupts of all channels
// - reading a pin register clears that pin's interrupts on all channels
// - reading the channel signal pins register clears all its sources for addressed channels
// - both debounce filters are timed from frame sync
// - hook filter samples each 250 us, restarts on change, counts 2 ms steps
// - key filter up/down counter 0..6 clocked at programmed period
// - key counter at 6 sets latch, at 0 clears, otherwise holds

`timescale 1ns/10ps
`default_nettype none
`include "slc_defines.svh"

module slc_signaling
#(
	// identification byte sent ahead of read data; value is arbitrary
	parameter logic [7:0] ID_CODE = 8'h5A
)
(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	// frame timing
	input  wire logic        frame_sync_i,
	// serial host port
	input  wire logic        serial_clk_i,
	input  wire logic        serial_cs_n_i,
	input  wire logic        serial_data_i,
	output logic             serial_data_o,
	output logic             serial_data_oe_o,
	// line interface pins, one bit per channel
	input  wire logic [3:0]  hook_input_i,
	input  wire logic [3:0]  ground_key_input_i,
	input  wire logic [3:0]  bidir_pin_one_i,
	output logic      [3:0]  bidir_pin_one_o,
	output logic      [3:0]  bidir_pin_one_oe_o,
	input  wire logic [3:0]  bidir_pin_two_i,
	output logic      [3:0]  bidir_pin_two_o,
	output logic      [3:0]  bidir_pin_two_oe_o,
	input  wire logic [3:0]  bidir_pin_three_i,
	output logic      [3:0]  bidir_pin_three_o,
	output logic      [3:0]  bidir_pin_three_oe_o,
	output logic      [3:0]  line_output_one_o,
	output logic      [3:0]  line_output_two_o,
	// interrupt, high while any enabled source is pending
	output logic             interrupt_o
);

	slc_pkg::slc_state_t s_reg;
	slc_pkg::slc_state_t s_next;
	slc_pkg::slc_state_t s_rst;

	// ======================================================================
	// reset image
	always_comb
	begin
		s_rst          = '0;
		s_rst.port_st  = slc_pkg::SLC_PS_CMD;
		s_rst.ch_en    = `SLC_RST_CH_EN;
		s_rst.trip_cfg = `SLC_RST_BYTE;
	end

	// ======================================================================
	// next state
	always_comb
	begin
		logic                  samp_tick;
		logic                  step_tick;
		logic                  key_clk;
		logic                  rise;
		logic                  fall;
		logic [2:0][3:0]       pin_in;
		logic [3:0][4:0]       cur;
		logic [3:0][4:0]       clr;
		logic [7:0]            wbyte;
		logic [7:0]            rdata;
		logic [1:0]            ctype;
		logic [4:0]            addr;
		logic [4:0]            outs;
		logic [2:0]            osel;
		logic                  in_lvl;
		logic                  trip;

		s_next    = s_reg;
		clr       = '0;
		rdata     = `SLC_RST_BYTE;
		samp_tick = 1'b0;
		step_tick = 1'b0;
		key_clk   = 1'b0;
		rise      = 1'b0;
		fall      = 1'b0;
		cur       = '0;
		outs      = '0;
		osel      = '0;
		in_lvl    = 1'b0;
		trip      = 1'b0;
		wbyte     = {s_reg.rx_sr[6:0], serial_data_i};
		ctype     = wbyte[`SLC_CMD_TYPE_HI:`SLC_CMD_TYPE_LO];
		addr      = wbyte[`SLC_CMD_ADDR_HI:`SLC_CMD_ADDR_LO];
		pin_in[0] = bidir_pin_one_i;
		pin_in[1] = bidir_pin_two_i;
		pin_in[2] = bidir_pin_three_i;

		// ==================================================================
		// frame sync pacing
		s_next.fs_q = frame_sync_i;
		if (frame_sync_i && !s_reg.fs_q)
		begin
			s_next.samp_cnt = s_reg.samp_cnt + 4'h1;
			s_next.step_cnt = s_reg.step_cnt + 4'h1;
			if (s_reg.samp_cnt == `SLC_SAMPLE_FRAMES - 4'h1)
			begin
				s_next.samp_cnt = '0;
				samp_tick       = 1'b1;
			end
			if (s_reg.step_cnt == `SLC_STEP_FRAMES)
			begin
				s_next.step_cnt = '0;
				step_tick       = 1'b1;
			end
		end

		// ==================================================================
		// debounce filters
		for (int c = 0; c < `SLC_NCH; c++)
		begin
			if (samp_tick && (hook_input_i[c] != s_reg.hook_smp[c]))
			begin
				s_next.hook_smp[c] = hook_input_i[c];
				s_next.hook_cnt[c] = '0;
			end
			else if (step_tick && (s_reg.hook_cnt[c] !=
				s_reg.deb_per[c][`SLC_HOOK_PER_HI:`SLC_HOOK_PER_LO]))
				s_next.hook_cnt[c] = s_reg.hook_cnt[c] + 4'h1;
			if (s_reg.hook_cnt[c] == s_reg.deb_per[c][`SLC_HOOK_PER_HI:`SLC_HOOK_PER_LO])
				s_next.hook_db[c] = s_reg.hook_smp[c];

			// zero period runs the key filter at the sample rate
			key_clk = 1'b0;
			if (s_reg.deb_per[c][`SLC_KEY_PER_HI:`SLC_KEY_PER_LO] == `SLC_ZERO_PERIOD)
				key_clk = samp_tick;
			else if (step_tick)
			begin
				s_next.key_tmr[c] = s_reg.key_tmr[c] + 4'h1;
				if (s_next.key_tmr[c] == s_reg.deb_per[c][`SLC_KEY_PER_HI:`SLC_KEY_PER_LO])
				begin
					s_next.key_tmr[c] = '0;
					key_clk           = 1'b1;
				end
			end
			if (key_clk)
			begin
				if (ground_key_input_i[c] && (s_reg.key_cnt[c] != `SLC_KEY_TOP))
					s_next.key_cnt[c] = s_reg.key_cnt[c] + 3'h1;
				else if (!ground_key_input_i[c] && (s_reg.key_cnt[c] != `SLC_KEY_BOTTOM))
					s_next.key_cnt[c] = s_reg.key_cnt[c] - 3'h1;
			end
			if (s_reg.key_cnt[c] == `SLC_KEY_TOP)
				s_next.key_db[c] = 1'b1;
			else if (s_reg.key_cnt[c] == `SLC_KEY_BOTTOM)
				s_next.key_db[c] = 1'b0;
		end

		// ==================================================================
		// source view per channel; pins in output mode show their register value
		for (int c = 0; c < `SLC_NCH; c++)
		begin
			cur[c][`SLC_SRC_HOOK] = s_reg.hook_db[c];
			cur[c][`SLC_SRC_KEY]  = s_reg.key_db[c];
			for (int p = 0; p < `SLC_NPIN; p++)
				cur[c][`SLC_SRC_PIN_ONE + p] = s_reg.pin_dir[p][c] ?
					s_reg.pin_val[p][c] : pin_in[p][c];
		end

		// ==================================================================
		// serial host port; cs high aborts any transfer
		s_next.sclk_q = serial_clk_i;
		rise          = serial_clk_i && !s_reg.sclk_q;
		fall          = !serial_clk_i && s_reg.sclk_q;
		if (serial_cs_n_i)
		begin
			s_next.port_st = slc_pkg::SLC_PS_CMD;
			s_next.bit_cnt = '0;
			s_next.tx_cnt  = '0;
			s_next.sdo_oe  = 1'b0;
		end
		else
		begin
			unique case (s_reg.port_st)
				slc_pkg::SLC_PS_CMD,
				slc_pkg::SLC_PS_WDATA:
				begin
					if (rise)
					begin
						s_next.rx_sr   = wbyte;
						s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
					end
					if (rise && (s_reg.bit_cnt == `SLC_BIT_LAST) &&
						(s_reg.port_st == slc_pkg::SLC_PS_CMD))
					begin
						s_next.cmd = wbyte;
						if (wbyte[`SLC_CMD_RW])
							s_next.port_st = slc_pkg::SLC_PS_WDATA;
						else
						begin
							s_next.port_st = slc_pkg::SLC_PS_READ;
							// local reads address the lowest enabled channel
							for (int c = `SLC_NCH - 1; c >= 0; c--)
							begin
								if (s_reg.ch_en[c] && (ctype == `SLC_TYPE_LOCAL))
								begin
									unique case (addr)
										`SLC_L_INT_ENABLE:  rdata = {3'h0, s_reg.int_en[c]};
										`SLC_L_DEB_PERIODS: rdata = s_reg.deb_per[c];
										`SLC_L_SIG_PINS:    rdata = {1'b0, s_reg.line_val[c], cur[c]};
										default:            rdata = `SLC_RST_BYTE;
									endcase
								end
								if (s_reg.ch_en[c] && (ctype == `SLC_TYPE_LOCAL) &&
									(addr == `SLC_L_SIG_PINS))
									clr[c] = '1;
							end
							if (ctype == `SLC_TYPE_GLOBAL)
							begin
								for (int c = 0; c < `SLC_NCH; c++)
								begin
									if (addr == `SLC_G_DEB_STATUS)
									begin
										clr[c][`SLC_SRC_HOOK] = 1'b1;
										clr[c][`SLC_SRC_KEY]  = 1'b1;
									end
									for (int p = 0; p < `SLC_NPIN; p++)
										if (addr == `SLC_G_PIN_ONE + 5'(p))
											clr[c][`SLC_SRC_PIN_ONE + p] = 1'b1;
								end
								unique case (addr)
									`SLC_G_CH_ENABLE:  rdata = {4'h0, s_reg.ch_en};
									`SLC_G_TRIP_CFG:   rdata = s_reg.trip_cfg;
									`SLC_G_DEB_STATUS: rdata = {s_reg.key_db, s_reg.hook_db};
									`SLC_G_PIN_ONE:    rdata = {s_reg.pin_dir[0],
										cur[3][2], cur[2][2], cur[1][2], cur[0][2]};
									`SLC_G_PIN_TWO:    rdata = {s_reg.pin_dir[1],
										cur[3][3], cur[2][3], cur[1][3], cur[0][3]};
									`SLC_G_PIN_THREE:  rdata = {s_reg.pin_dir[2],
										cur[3][4], cur[2][4], cur[1][4], cur[0][4]};
									default:           rdata = `SLC_RST_BYTE;
								endcase
							end
							s_next.tx_sr  = {ID_CODE, rdata};
							s_next.tx_cnt = '0;
						end
					end
					else if (rise && (s_reg.bit_cnt == `SLC_BIT_LAST))
					begin
						s_next.port_st = slc_pkg::SLC_PS_DONE;
						ctype = s_reg.cmd[`SLC_CMD_TYPE_HI:`SLC_CMD_TYPE_LO];
						addr  = s_reg.cmd[`SLC_CMD_ADDR_HI:`SLC_CMD_ADDR_LO];
						if (ctype == `SLC_TYPE_LOCAL)
						begin
							// writes reach every enabled channel
							for (int c = 0; c < `SLC_NCH; c++)
							begin
								if (s_reg.ch_en[c])
								begin
									unique case (addr)
										`SLC_L_INT_ENABLE:  s_next.int_en[c] = wbyte[4:0];
										`SLC_L_DEB_PERIODS: s_next.deb_per[c] = wbyte;
										`SLC_L_SIG_PINS:    s_next.line_val[c] =
											{wbyte[`SLC_SIG_LINE_TWO], wbyte[`SLC_SIG_LINE_ONE]};
										default:            ;
									endcase
								end
							end
						end
						else if (ctype == `SLC_TYPE_GLOBAL)
						begin
							unique case (addr)
								`SLC_G_INT_CLEAR:  clr = '1;
								`SLC_G_CH_ENABLE:  s_next.ch_en = wbyte[3:0];
								`SLC_G_TRIP_CFG:   s_next.trip_cfg = wbyte & `SLC_TRIP_CFG_MASK;
								`SLC_G_PIN_ONE:    {s_next.pin_dir[0], s_next.pin_val[0]} = wbyte;
								`SLC_G_PIN_TWO:    {s_next.pin_dir[1], s_next.pin_val[1]} = wbyte;
								`SLC_G_PIN_THREE:  {s_next.pin_dir[2], s_next.pin_val[2]} = wbyte;
								default:           ;
							endcase
						end
					end
					if (rise && (s_reg.bit_cnt == `SLC_BIT_LAST))
						s_next.bit_cnt = '0;
				end
				slc_pkg::SLC_PS_READ:
				begin
					if (fall)
					begin
						s_next.sdo    = s_reg.tx_sr[15];
						s_next.sdo_oe = 1'b1;
						s_next.tx_sr  = {s_reg.tx_sr[14:0], 1'b0};
						s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
						if (s_reg.tx_cnt == `SLC_TX_LAST)
							s_next.port_st = slc_pkg::SLC_PS_DONE;
					end
				end
				slc_pkg::SLC_PS_DONE:
				begin
					// last bit stays on the wire until the next falling edge
					if (fall)
						s_next.sdo_oe = 1'b0;
				end
			endcase
		end

		// ==================================================================
		// change detect; a new event beats a clear in the same cycle
		s_next.src_q = cur;
		for (int c = 0; c < `SLC_NCH; c++)
		begin
			for (int k = 0; k < `SLC_NSRC; k++)
			begin
				if (clr[c][k])
					s_next.pend[c][k] = 1'b0;
				if ((cur[c][k] != s_reg.src_q[c][k]) && s_reg.int_en[c][k] &&
					((k < `SLC_SRC_PIN_ONE) ||
					!s_reg.pin_dir[(k < `SLC_SRC_PIN_ONE) ? 0 : k - `SLC_SRC_PIN_ONE][c]))
					s_next.pend[c][k] = 1'b1;
			end
		end
		s_next.irq = |s_next.pend;

		// ==================================================================
		// pin drivers with hardware ring trip
		osel = s_reg.trip_cfg[`SLC_TRIP_OUT_HI:`SLC_TRIP_OUT_LO];
		for (int c = 0; c < `SLC_NCH; c++)
		begin
			outs   = {s_reg.pin_val[2][c], s_reg.pin_val[1][c], s_reg.pin_val[0][c],
				s_reg.line_val[c]};
			in_lvl = s_reg.trip_cfg[`SLC_TRIP_IN_SEL] ? s_reg.key_db[c] : s_reg.hook_db[c];
			trip   = s_reg.trip_cfg[`SLC_TRIP_EN] &&
				(in_lvl == s_reg.trip_cfg[`SLC_TRIP_IN_POL]);
			// only a ringing output is flipped, an idle one is left alone
			if (trip && (osel <= `SLC_OSEL_PIN_THREE) &&
				(outs[osel] == s_reg.trip_cfg[`SLC_TRIP_OUT_POL]))
				outs[osel] = !outs[osel];
			s_next.line_one_drv[c] = outs[`SLC_OSEL_LINE_ONE];
			s_next.line_two_drv[c] = outs[`SLC_OSEL_LINE_TWO];
			for (int p = 0; p < `SLC_NPIN; p++)
				s_next.pin_drv[p][c] = outs[`SLC_OSEL_PIN_ONE + 3'(p)];
		end
	end

	// ======================================================================
	// state register
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
			s_reg <= s_rst;
		else
			s_reg <= s_next;
	end

	assign serial_data_o        = s_reg.sdo;
	assign serial_data_oe_o     = s_reg.sdo_oe;
	assign bidir_pin_one_o      = s_reg.pin_drv[0];
	assign bidir_pin_two_o      = s_reg.pin_drv[1];
	assign bidir_pin_three_o    = s_reg.pin_drv[2];
	assign bidir_pin_one_oe_o   = s_reg.pin_dir[0];
	assign bidir_pin_two_oe_o   = s_reg.pin_dir[1];
	assign bidir_pin_three_oe_o = s_reg.pin_dir[2];
	assign line_output_one_o    = s_reg.line_one_drv;
	assign line_output_two_o    = s_reg.line_two_drv;
	assign interrupt_o          = s_reg.irq;

endmodule

`default_nettype wire

// *** bench/slc_slic_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========
// line interface circuit on the three shared pins of four channels
module slc_slic_model
(
	// levels the line circuit offers, {three, two, one}
	input  wire logic [11:0] lvl_i,
	// device side
	input  wire logic [11:0] dev_i,
	input  wire logic [11:0] dev_oe_i,
	// resolved wire levels
	output logic      [11:0] wire_o
);
	// the line circuit drives a pin only while the device lets go of it
	assign wire_o = (dev_oe_i & dev_i) | (~dev_oe_i & lvl_i);
endmodule
`default_nettype wire

// *** bench/slc_signaling_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========
// port checker
module slc_signaling_chk
(
	// clock, reset, timing
	input wire logic       ref_clk_i,
	input wire logic       reset_n_i,
	input wire logic       frame_sync_i,
	// host port
	input wire logic       serial_clk_i,
	input wire logic       serial_cs_n_i,
	input wire logic       serial_data_o,
	input wire logic       serial_data_oe_o,
	// line pins
	input wire logic [3:0] bidir_pin_one_i,
	input wire logic [3:0] bidir_pin_two_i,
	input wire logic [3:0] bidir_pin_three_i,
	input wire logic [3:0] bidir_pin_one_o,
	input wire logic [3:0] bidir_pin_one_oe_o,
	input wire logic [3:0] bidir_pin_two_oe_o,
	input wire logic [3:0] bidir_pin_three_oe_o,
	input wire logic [3:0] line_output_one_o,
	input wire logic [3:0] line_output_two_o,
	input wire logic       interrupt_o
);
	// cycles since the last host access, frame tick and pin change
	logic [3:0]  cs_age;
	logic [3:0]  fs_age;
	logic [3:0]  pin_age;
	logic        fs_q;
	logic [11:0] pins;
	logic [11:0] pins_q;

	assign pins = {bidir_pin_three_i, bidir_pin_two_i, bidir_pin_one_i};

	always_ff @(posedge ref_clk_i)
	begin
		fs_q    <= frame_sync_i;
		pins_q  <= pins;
		cs_age  <= (!reset_n_i || !serial_cs_n_i) ? 4'h0 : cs_age + 4'(cs_age != 4'hF);
		fs_age  <= (!reset_n_i || (frame_sync_i && !fs_q)) ? 4'h0 : fs_age + 4'(fs_age != 4'hF);
		pin_age <= (!reset_n_i || pins != pins_q) ? 4'h0 : pin_age + 4'(pin_age != 4'hF);
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// a host read bit may only move after a falling host clock was seen
	sequence s_fall_seen;
		$past(serial_clk_i, 2) && !$past(serial_clk_i);
	endsequence

	a_irq_set_cause: assert property (
		$rose(interrupt_o) |-> fs_age <= 4'h6 || pin_age <= 4'h5 || cs_age <= 4'h3)
		else $error("interrupt rose without a source change");
	a_irq_clear_host: assert property (
		$fell(interrupt_o) |-> cs_age <= 4'h3)
		else $error("interrupt fell without a host access");
	a_oe_drop_idle: assert property (
		serial_cs_n_i |=> !serial_data_oe_o)
		else $error("read data driven while deselected");
	a_oe_start_fall: assert property (
		$rose(serial_data_oe_o) |-> s_fall_seen)
		else $error("read drive began off a falling edge");
	a_sdo_on_fall: assert property (
		$changed(serial_data_o) && serial_data_oe_o |-> s_fall_seen)
		else $error("read bit moved off a falling edge");
	a_dir_by_host: assert property (
		$changed({bidir_pin_three_oe_o, bidir_pin_two_oe_o, bidir_pin_one_oe_o})
		|-> !$past(serial_cs_n_i, 2)) else $error("pin direction moved without a write");
	a_pin_drive_cause: assert property (
		$changed(bidir_pin_one_o) |-> cs_age <= 4'h3 || fs_age <= 4'h6)
		else $error("pin level moved without a cause");
	a_line_drive_cause: assert property (
		$changed({line_output_two_o, line_output_one_o}) |-> cs_age <= 4'h3 || fs_age <= 4'h6)
		else $error("line output moved without a cause");
endmodule

bind slc_signaling slc_signaling_chk u_slc_signaling_chk
(
	.ref_clk_i, .reset_n_i, .frame_sync_i, .serial_clk_i, .serial_cs_n_i,
	.serial_data_o, .serial_data_oe_o, .bidir_pin_one_i, .bidir_pin_two_i,
	.bidir_pin_three_i, .bidir_pin_one_o, .bidir_pin_one_oe_o, .bidir_pin_two_oe_o,
	.bidir_pin_three_oe_o, .line_output_one_o, .line_output_two_o, .interrupt_o
);
`default_nettype wire

// *** bench/slc_signaling_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "slc_defines.svh"
// ==========
// bench top
module slc_signaling_test;
	localparam logic [7:0] ID_BYTE = 8'hC3; // arbitrary id value
	logic            ref_clk_i = 1'b0;
	logic            reset_n_i = 1'b0;
	logic            frame_sync_i = 1'b0;
	logic            serial_clk_i = 1'b1;
	logic            serial_cs_n_i = 1'b1;
	logic            serial_data_i = 1'b0;
	logic            serial_data_o;
	logic            serial_data_oe_o;
	logic [3:0]      hook_input_i = 4'h0;
	logic [3:0]      ground_key_input_i = 4'h0;
	logic [11:0]     lvl = 12'h000;
	logic [11:0]     pin_wire;
	wire  [2:0][3:0] pin_o;
	wire  [2:0][3:0] pin_oe;
	logic [3:0]      line_output_one_o;
	logic [3:0]      line_output_two_o;
	logic            interrupt_o;
	int              checked = 0;
	int              n_mismatch = 0;
	int              k;
	logic [7:0]      cfg_t [6] = '{8'h86, 8'h82, 8'h02, 8'h84, 8'hC6, 8'h8C};
	logic [7:0]      exp_t [6] = '{8'h0C, 8'h03, 8'h0F, 8'h0F, 8'h0A, 8'h3F};

	slc_signaling #(.ID_CODE(ID_BYTE)) u_slc_signaling
	(
		.ref_clk_i, .reset_n_i, .frame_sync_i, .serial_clk_i, .serial_cs_n_i,
		.serial_data_i, .serial_data_o, .serial_data_oe_o, .hook_input_i, .ground_key_input_i,
		.bidir_pin_one_i(pin_wire[3:0]), .bidir_pin_one_o(pin_o[0]), .bidir_pin_one_oe_o(pin_oe[0]),
		.bidir_pin_two_i(pin_wire[7:4]), .bidir_pin_two_o(pin_o[1]), .bidir_pin_two_oe_o(pin_oe[1]),
		.bidir_pin_three_i(pin_wire[11:8]), .bidir_pin_three_o(pin_o[2]),
		.bidir_pin_three_oe_o(pin_oe[2]), .line_output_one_o, .line_output_two_o, .interrupt_o
	);

	slc_slic_model u_slc_slic_model
	(
		.lvl_i   (lvl),
		.dev_i   (pin_o),
		.dev_oe_i(pin_oe),
		.wire_o  (pin_wire)
	);

	always #2.5 ref_clk_i = ~ref_clk_i;

	// ==========
	// tasks
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	// frames shortened to 64 clocks so the filters settle quickly
	always
	begin
		tick(63);
		frame_sync_i = 1'b1;
		tick(1);
		frame_sync_i = 1'b0;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask

	// host clock idles high; 3 clocks per half period
	task automatic xfer(input logic [7:0] c, input logic [7:0] d, output logic [15:0] r);
		logic [15:0] cd;
		cd = {c, d};
		serial_cs_n_i = 1'b0;
		tick(3);
		for (int i = 0; i < (c[7] ? 16 : 24); i++)
		begin
			serial_clk_i = 1'b0;
			serial_data_i = (i < 16) ? cd[15 - i] : 1'b0;
			tick(3);
			r = {r[14:0], serial_data_o};
			serial_clk_i = 1'b1;
			tick(3);
		end
		tick(3);
		serial_cs_n_i = 1'b1;
		tick(3);
	endtask

	task automatic wr(input logic [1:0] t, input logic [4:0] a, input logic [7:0] d);
		logic [15:0] r;
		xfer({1'b1, t, a}, d, r);
	endtask

	task automatic rd(input logic [1:0] t, input logic [4:0] a, input logic [7:0] m, e);
		logic [15:0] r;
		xfer({1'b0, t, a}, 8'h00, r);
		chk(r[15:8], ID_BYTE);
		chk(r[7:0] & m, e);
	endtask

	task automatic irq(input logic e);
		chk({7'h0, interrupt_o}, {7'h0, e});
	endtask

	task automatic flip(input logic [11:0] m, input logic e);
		lvl = lvl ^ m;
		tick(8);
		irq(e);
	endtask

	task automatic report_and_stop;
		$display("checked %0d, n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		tick(40000);
		n_mismatch++;
		report_and_stop;
	end

	// ==========
	// tests
	initial
	begin
		tick(4);
		reset_n_i = 1'b1;
		tick(3);
		rd(`SLC_TYPE_GLOBAL, `SLC_G_TRIP_CFG, 8'hFF, 8'h00);
		rd(`SLC_TYPE_LOCAL, `SLC_L_INT_ENABLE, 8'hFF, 8'h00);
		rd(`SLC_TYPE_LOCAL, `SLC_L_DEB_PERIODS, 8'hFF, 8'h00);
		for (k = 0; k < 3; k++)
		begin
			wr(`SLC_TYPE_GLOBAL, `SLC_G_PIN_ONE + 5'(k), 8'h9F);
			chk({pin_oe[k], pin_o[k] & pin_oe[k]}, 8'h99);
			rd(`SLC_TYPE_GLOBAL, `SLC_G_PIN_ONE + 5'(k), 8'hFF, 8'h99);
			wr(`SLC_TYPE_GLOBAL, `SLC_G_PIN_ONE + 5'(k), 8'h00);
		end
		wr(`SLC_TYPE_LOCAL, `SLC_L_SIG_PINS, 8'h60);
		chk({line_output_two_o, line_output_one_o}, 8'h11);
		rd(`SLC_TYPE_LOCAL, `SLC_L_SIG_PINS, 8'h60, 8'h60);
		wr(`SLC_TYPE_GLOBAL, `SLC_G_CH_ENABLE, 8'h0F);
		wr(`SLC_TYPE_LOCAL, `SLC_L_SIG_PINS, 8'h20);
		chk({line_output_two_o, line_output_one_o}, 8'h0F);
		// change detection on the pins
		wr(`SLC_TYPE_GLOBAL, `SLC_G_INT_CLEAR, 8'h00);
		wr(`SLC_TYPE_LOCAL, `SLC_L_INT_ENABLE, 8'h1F);
		flip(12'h001, 1'b1);
		rd(`SLC_TYPE_LOCAL, `SLC_L_SIG_PINS, 8'h04, 8'h04);
		irq(1'b0);
		flip(12'h010, 1'b1);
		rd(`SLC_TYPE_GLOBAL, `SLC_G_PIN_ONE, 8'h0F, 8'h01);
		irq(1'b1);
		rd(`SLC_TYPE_GLOBAL, `SLC_G_PIN_TWO, 8'h0F, 8'h01);
		irq(1'b0);
		flip(12'h100, 1'b1);
		wr(`SLC_TYPE_GLOBAL, `SLC_G_INT_CLEAR, 8'h00);
		irq(1'b0);
		wr(`SLC_TYPE_LOCAL, `SLC_L_INT_ENABLE, 8'h04);
		flip(12'h100, 1'b0);
		flip(12'h001, 1'b1);
		wr(`SLC_TYPE_GLOBAL, `SLC_G_INT_CLEAR, 8'h00);
		// debounce: hook period 2 steps, key every sample
		wr(`SLC_TYPE_LOCAL, `SLC_L_INT_ENABLE, 8'h03);
		wr(`SLC_TYPE_LOCAL, `SLC_L_DEB_PERIODS, 8'h20);
		hook_input_i = 4'h3;
		ground_key_input_i = 4'h5;
		tick(6 * 64);
		rd(`SLC_TYPE_GLOBAL, `SLC_G_DEB_STATUS, 8'hFF, 8'h00);
		tick(36 * 64);
		irq(1'b1);
		rd(`SLC_TYPE_GLOBAL, `SLC_G_DEB_STATUS, 8'hFF, 8'h53);
		irq(1'b0);
		rd(`SLC_TYPE_LOCAL, `SLC_L_SIG_PINS, 8'h03, 8'h03);
		// ring trip settings against hook 3 and key 5
		for (k = 0; k < 6; k++)
		begin
			wr(`SLC_TYPE_GLOBAL, `SLC_G_TRIP_CFG, cfg_t[k]);
			chk({line_output_two_o, line_output_one_o}, exp_t[k]);
			rd(`SLC_TYPE_GLOBAL, `SLC_G_TRIP_CFG, 8'hFF, cfg_t[k]);
		end
		// ring trip onto pin one, driven high as ringing level
		wr(`SLC_TYPE_GLOBAL, `SLC_G_PIN_ONE, 8'hFF);
		wr(`SLC_TYPE_GLOBAL, `SLC_G_TRIP_CFG, 8'h96);
		chk({pin_oe[0], pin_o[0]}, 8'hFC);
		// key filter clocked once per 2 ms step
		wr(`SLC_TYPE_LOCAL, `SLC_L_DEB_PERIODS, 8'h21);
		ground_key_input_i = 4'hA;
		tick(48 * 64);
		rd(`SLC_TYPE_GLOBAL, `SLC_G_DEB_STATUS, 8'hF0, 8'h50);
		tick(80 * 64);
		rd(`SLC_TYPE_GLOBAL, `SLC_G_DEB_STATUS, 8'hF0, 8'hA0);
		report_and_stop;
	end
endmodule
`default_nettype wire
